// file: logic/ecp_defs.svh
// offsets, mode codes, reset values and timing of the parallel port
// assumes a 100 MHz sys_clk; included by its bare name
// Function
// - port word is eight bits everywhere
// - forward host to peripheral, reverse back
// - status and control reachable in all modes
// - all FIFO ports share one 16-byte buffer
// - second config reflects chosen IRQ and DMA
// - behaves as ordinary printer port otherwise
// - no negotiation; DMA burst both directions
// - compatibility strobe and busy done in hardware
// - reverse run-length bytes expanded in hardware
// - hardware compression optional, count before byte
// - strobe clocks byte in, interlocked with busy
// - wait reverse acknowledge before driving data bus
// - host ack requests reverse byte, tags forward
// - fault raises error interrupt in forward only
// - nInit low means reverse, high forward
// - nSelectIn held deasserted in extended mode
// - three-bit mode field selects operating mode
// - address port queues tagged forward command bytes
// - status top bit inverse busy, low bits zero
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

// register indices, byte address is four times the index
`define ECP_IDX_DATA     11'h000
`define ECP_IDX_STATUS   11'h001
`define ECP_IDX_CONTROL  11'h002
`define ECP_IDX_FIFO     11'h400
`define ECP_IDX_CFG2     11'h401
`define ECP_IDX_XCTL     11'h402

// operating modes
`define ECP_M_STD        3'h0
`define ECP_M_BIDIR      3'h1
`define ECP_M_COMPAT_FIFO_PORT      3'h2
`define ECP_M_ECP        3'h3
`define ECP_M_TEST       3'h6
`define ECP_M_CFG        3'h7

// fixed read values and reset values
`define ECP_CFG1_VAL     8'h08
`define ECP_MODE_RST     3'h0
`define ECP_NERR_RST     1'h1
`define ECP_SVC_RST      1'h1

// bus answers
`define ECP_RESP_OKAY    2'h0
`define ECP_RESP_SLVERR  2'h2

// compatibility handshake timing
`define ECP_CLK_MHZ      100
`define ECP_SETUP_NS     500
`define ECP_STB_NS       500
`define ECP_SETUP_CYC    ((`ECP_SETUP_NS * `ECP_CLK_MHZ + 999) / 1000)
`define ECP_STB_CYC      ((`ECP_STB_NS * `ECP_CLK_MHZ + 999) / 1000)

`endif

// file: logic/ecp_fifo.sv
// shared byte FIFO with tag bit, flip-flop storage
// assumes power-of-two depth and one clock with the caller
module ecp_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // control
  input  wire logic         flush,
  input  wire logic         push,
  input  wire logic [W-1:0] din,
  input  wire logic         pop,
  // status and head
  output logic      [W-1:0] dout,
  output logic              full,
  output logic              empty
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            last;
  } st_s;

  st_s  q;
  st_s  n;
  logic do_push;
  logic do_pop;

  // honest flags from the true count
  assign full    = q.cnt == (AW+1)'(DEPTH);
  assign empty   = q.cnt == '0;
  assign do_push = push && !full;  // full drops the byte
  assign do_pop  = pop && !empty;  // empty re-reads last
  assign dout    = empty ? q.last : q.mem[q.rp];

  // pointer and storage update
  always_comb begin
    n = q;
    if (do_pop) begin
      n.last = q.mem[q.rp];
      n.rp   = q.rp + 1'b1;
    end
    if (do_push) begin
      n.mem[q.wp] = din;
      n.wp        = q.wp + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule // ecp_fifo

// file: logic/ecp_parallel_port.sv
// host-side extended capabilities parallel port with AXI4-Lite registers
// assumes peripheral lines asynchronous, AXI master on sys_clk
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`include "ecp_defs.svh"

module ecp_parallel_port #(
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // axi4-lite write
  input  wire logic [12:0]       awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [12:0]       araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // chip configuration
  input  wire logic [2:0]        cfg_irq_sel,
  input  wire logic [2:0]        cfg_dma_sel,
  input  wire logic              irq_line_level,
  // parallel link
  input  wire ecp_pkg::pin_in_s  pins_in,
  output ecp_pkg::pin_out_s      pins_out,
  // system requests
  output logic                   err_irq,
  output logic                   dma_req
);

  typedef struct packed {
    ecp_pkg::pin_in_s s1;
    ecp_pkg::pin_in_s s2;
    logic             aw_v;
    logic [10:0]      aw_i;
    logic             w_v;
    logic [7:0]       wd;
    logic             w_en;
    logic             b_v;
    logic [1:0]       b_r;
    logic             r_v;
    logic [7:0]       rd;
    logic [1:0]       r_r;
    logic [7:0]       dat;
    ecp_pkg::ctl_s    ctl;
    logic [2:0]       mode;
    logic             nerr;
    logic             dma;
    logic             svc;
    ecp_pkg::eng_e    eng;
    logic [7:0]       byt;
    logic             hack;
    logic             nstb;
    logic [7:0]       cnt;
    logic [7:0]       rle;
    logic [7:0]       reps;
  } st_s;

  localparam logic [7:0] SETUP_C = 8'(`ECP_SETUP_CYC);
  localparam logic [7:0] STB_C   = 8'(`ECP_STB_CYC);

  st_s              q;
  st_s              n;
  ecp_pkg::pin_in_s p;
  logic             dir_eff;
  logic             fwd_m;
  logic             rev_m;
  logic             ecp_m;
  logic             fifo_m;
  logic             drive;
  logic             f_push;
  logic             f_pop;
  logic             f_flush;
  logic [8:0]       f_din;
  logic [8:0]       f_dout;
  logic             f_full;
  logic             f_empty;
  logic             svc_set;
  logic [10:0]      ar_i;

  // one buffer behind every FIFO port, byte plus command tag
  ecp_fifo #(
    .W     (9),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .flush   (f_flush),
    .push    (f_push),
    .din     (f_din),
    .pop     (f_pop),
    .dout    (f_dout),
    .full    (f_full),
    .empty   (f_empty)
  );

  // mode decode and effective direction
  assign p       = q.s2;
  assign ecp_m   = q.mode == `ECP_M_ECP;
  assign dir_eff = q.ctl.dir && q.mode != `ECP_M_STD && q.mode != `ECP_M_COMPAT_FIFO_PORT;
  assign fwd_m   = q.mode == `ECP_M_COMPAT_FIFO_PORT || (ecp_m && !dir_eff);
  assign rev_m   = ecp_m && dir_eff;
  assign fifo_m  = q.mode == `ECP_M_COMPAT_FIFO_PORT || ecp_m || q.mode == `ECP_M_TEST;
  assign svc_set = fifo_m && !q.dma && (fwd_m ? f_empty : (rev_m && f_full));
  assign ar_i    = araddr[12:2];

  // bus handshakes
  assign awready = !q.aw_v;
  assign wready  = !q.w_v;
  assign bvalid  = q.b_v;
  assign bresp   = q.b_r;
  assign arready = !q.r_v;
  assign rvalid  = q.r_v;
  assign rresp   = q.r_r;
  assign rdata   = {24'h000000, q.rd};

  // data bus drive waits for the reverse acknowledge to clear
  assign drive = !dir_eff && (!ecp_m || p.perror);

  // link pins, plain printer port outside the engine modes
  always_comb begin
    pins_out.pd        = fwd_m ? q.byt : q.dat;
    pins_out.pd_oe_n   = !drive;
    pins_out.nstrobe   = (q.mode == `ECP_M_COMPAT_FIFO_PORT || ecp_m) ? q.nstb : !q.ctl.strobe;
    pins_out.nautofd   = ecp_m ? q.hack : !q.ctl.autofd;
    pins_out.ninit     = ecp_m ? !dir_eff : q.ctl.ninit;
    pins_out.nselectin = ecp_m ? 1'b1 : !q.ctl.selin;
  end

  // fault interrupt is forward-only and gated by its mask
  assign err_irq = ecp_m && !dir_eff && !p.nfault && !q.nerr;
  // burst request toward the DMA controller
  assign dma_req = q.dma && fifo_m && !q.svc && (fwd_m ? !f_full : !f_empty);

  // next state: bus slave, registers and link engine
  always_comb begin
    n       = q;
    f_push  = 1'b0;
    f_pop   = 1'b0;
    f_flush = 1'b0;
    f_din   = 9'h000;
    n.s1    = pins_in;
    n.s2    = q.s1;

    // write address and data taken in either order
    if (awvalid && !q.aw_v) begin
      n.aw_v = 1'b1;
      n.aw_i = awaddr[12:2];
    end
    if (wvalid && !q.w_v) begin
      n.w_v  = 1'b1;
      n.wd   = wdata[7:0];
      n.w_en = wstrb[0];
    end
    if (q.b_v && bready) begin
      n.b_v = 1'b0;
    end

    // write effects once both halves are held
    if (q.aw_v && q.w_v && !q.b_v) begin
      n.aw_v = 1'b0;
      n.w_v  = 1'b0;
      n.b_v  = 1'b1;
      n.b_r  = `ECP_RESP_OKAY;
      case (q.aw_i)
        `ECP_IDX_DATA: begin
          if (q.w_en && (q.mode == `ECP_M_STD || q.mode == `ECP_M_BIDIR)) begin
            n.dat = q.wd;
          end else if (q.w_en && ecp_m && !dir_eff) begin
            f_push = 1'b1;
            f_din  = {1'b1, q.wd};
          end
        end
        `ECP_IDX_STATUS: begin
        end
        `ECP_IDX_CONTROL: begin
          if (q.w_en) begin
            n.ctl = q.wd[5:0];
          end
        end
        `ECP_IDX_FIFO: begin
          if (q.w_en && fifo_m && (q.mode == `ECP_M_TEST || !dir_eff)) begin
            f_push = 1'b1;
            f_din  = {1'b0, q.wd};
          end
        end
        `ECP_IDX_CFG2: begin
        end
        `ECP_IDX_XCTL: begin
          if (q.w_en) begin
            n.mode = q.wd[7:5];
            n.nerr = q.wd[4];
            n.dma  = q.wd[3];
            n.svc  = q.wd[2];
            f_flush = q.wd[7:5] == `ECP_M_STD || q.wd[7:5] == `ECP_M_BIDIR;
          end
        end
        default: begin
          n.b_r = `ECP_RESP_SLVERR;
        end
      endcase
    end
    // hardware set wins over a software clear
    if (svc_set) begin
      n.svc = 1'b1;
    end

    // read answer one cycle after the address is taken
    if (q.r_v && rready) begin
      n.r_v = 1'b0;
    end
    if (arvalid && !q.r_v) begin
      n.r_v = 1'b1;
      n.r_r = `ECP_RESP_OKAY;
      n.rd  = 8'h00;
      case (ar_i)
        `ECP_IDX_DATA: begin
          if (!ecp_m) begin
            n.rd = p.pd;
          end
        end
        `ECP_IDX_STATUS: begin
          n.rd = {!p.busy, p.nack, p.perror, p.select, p.nfault, 3'h0};
        end
        `ECP_IDX_CONTROL: begin
          n.rd = {2'h0, q.ctl};
        end
        `ECP_IDX_FIFO: begin
          if (q.mode == `ECP_M_CFG) begin
            n.rd = `ECP_CFG1_VAL;
          end else if (fifo_m) begin
            n.rd  = f_dout[7:0];
            f_pop = q.mode == `ECP_M_TEST || rev_m;
          end
        end
        `ECP_IDX_CFG2: begin
          // compression bit reads zero: no hardware compression
          n.rd = {1'b0, irq_line_level, cfg_irq_sel, cfg_dma_sel};
        end
        `ECP_IDX_XCTL: begin
          n.rd = {q.mode, q.nerr, q.dma, q.svc, f_full, f_empty};
        end
        default: begin
          n.r_r = `ECP_RESP_SLVERR;
        end
      endcase
    end

    // link engine
    case (q.eng)
      ecp_pkg::E_IDLE: begin
        if (fwd_m && !f_empty) begin
          f_pop  = 1'b1;
          n.byt  = f_dout[7:0];
          n.hack = !(ecp_m && f_dout[8]);
          n.cnt  = SETUP_C;
          n.eng  = ecp_pkg::E_FWAIT;
        end else if (rev_m && !p.perror && !f_full) begin
          n.hack = 1'b0;
          n.eng  = ecp_pkg::E_RREQ;
        end
      end
      ecp_pkg::E_FWAIT: begin
        if (q.cnt != 8'h00) begin
          n.cnt = q.cnt - 8'h01;
        end else if (!p.busy) begin
          n.nstb = 1'b0;
          n.cnt  = STB_C - 8'h01;                         // entry edge is the first low cycle
          n.eng  = ecp_pkg::E_FSTB;
        end
      end
      ecp_pkg::E_FSTB: begin
        if (ecp_m) begin
          if (p.busy) begin
            n.nstb = 1'b1;
            n.eng  = ecp_pkg::E_FREL;
          end
        end else if (q.cnt != 8'h00) begin
          n.cnt = q.cnt - 8'h01;
        end else begin
          n.nstb = 1'b1;
          n.eng  = ecp_pkg::E_IDLE;
        end
      end
      ecp_pkg::E_FREL: begin
        if (!p.busy) begin
          n.eng = ecp_pkg::E_IDLE;
        end
      end
      ecp_pkg::E_RREQ: begin
        if (!p.nack) begin
          n.hack = 1'b1;
          n.eng  = ecp_pkg::E_RREL;
          if (p.busy) begin
            n.byt  = p.pd;
            n.reps = (q.rle != 8'h00) ? q.rle : 8'h01;
            n.rle  = 8'h00;
          end else if (!p.pd[7]) begin
            n.rle = {1'b0, p.pd[6:0]} + 8'h01;
          end
        end
      end
      ecp_pkg::E_RREL: begin
        if (p.nack) begin
          n.eng = (q.reps != 8'h00) ? ecp_pkg::E_RRPT : ecp_pkg::E_IDLE;
        end
      end
      ecp_pkg::E_RRPT: begin
        if (q.reps == 8'h00) begin
          n.eng = ecp_pkg::E_IDLE;
        end else if (!f_full) begin
          f_push = 1'b1;
          f_din  = {1'b0, q.byt};
          n.reps = q.reps - 8'h01;
        end
      end
      default: begin
        n.eng = ecp_pkg::E_IDLE;
      end
    endcase

    // switching to standard or bidirectional mode abandons any transfer
    if (f_flush) begin
      n.eng  = ecp_pkg::E_IDLE;
      n.nstb = 1'b1;
      n.hack = 1'b1;
      n.reps = 8'h00;
      n.rle  = 8'h00;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q      <= '0;
      q.mode <= `ECP_MODE_RST;
      q.nerr <= `ECP_NERR_RST;
      q.svc  <= `ECP_SVC_RST;
      q.nstb <= 1'b1;
      q.hack <= 1'b1;
    end else begin
      q <= n;
    end
  end
endmodule // ecp_parallel_port

// file: logic/ecp_pkg.sv
// types shared by the parallel port files
// assumes nothing beyond a SystemVerilog compiler
package ecp_pkg;

  // link engine states
  typedef enum logic [2:0] {
    E_IDLE, E_FWAIT, E_FSTB, E_FREL, E_RREQ, E_RREL, E_RRPT
  } eng_e;

  // software control bits, low six bits of the control register
  typedef struct packed {
    logic dir;
    logic ackint;
    logic selin;
    logic ninit;
    logic autofd;
    logic strobe;
  } ctl_s;

  // peripheral lines into the port
  typedef struct packed {
    logic       nack;
    logic       busy;
    logic       perror;
    logic       select;
    logic       nfault;
    logic [7:0] pd;
  } pin_in_s;

  // lines driven toward the peripheral
  typedef struct packed {
    logic       nstrobe;
    logic       nautofd;
    logic       ninit;
    logic       nselectin;
    logic       pd_oe_n;
    logic [7:0] pd;
  } pin_out_s;

endpackage

// file: verification/ecp_parallel_port_asserts.sv
// concurrent checks on the parallel port, bound to its top module
// assumes the register master offers write address and data together
`include "ecp_defs.svh"
module ecp_parallel_port_chk #(
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              nrst,
  // register bus
  input wire logic [12:0]       awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [12:0]       araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  // configuration and link
  input wire logic [2:0]        cfg_irq_sel,
  input wire logic [2:0]        cfg_dma_sel,
  input wire logic              irq_line_level,
  input wire ecp_pkg::pin_in_s  pins_in,
  input wire ecp_pkg::pin_out_s pins_out,
  input wire logic              err_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  md_ff;
  logic        cd_ff;
  logic [12:0] ra_ff;
  logic [7:0]  lo_ff;
  logic        wr_go;
  assign wr_go = awvalid && awready && wvalid && wready && wstrb[0];
  // mirror of mode, direction, read address and strobe-low count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      md_ff <= 3'h0;
      cd_ff <= 1'b0;
      ra_ff <= 13'h0;
      lo_ff <= 8'h0;
    end else begin
      if (wr_go && awaddr == 13'h1008) md_ff <= wdata[7:5];
      if (wr_go && awaddr == 13'h0008) cd_ff <= wdata[5];
      if (arvalid && arready) ra_ff <= araddr;
      lo_ff <= pins_out.nstrobe ? 8'h0 : lo_ff + 8'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_sel_off; md_ff == 3'h3 && $past(md_ff) == 3'h3 |-> pins_out.nselectin; endproperty
  a_sel_off: assert property (p_sel_off) else $error("select-in low in extended mode");
  property p_rmap; $rose(rvalid) |-> rresp == ((ra_ff inside {13'h0, 13'h4, 13'h8, 13'h1000, 13'h1004,
    13'h1008}) ? 2'h0 : 2'h2); endproperty
  a_rmap: assert property (p_rmap) else $error("read response wrong for address");
  property p_stat0; rvalid && ra_ff == 13'h4 |-> rdata[2:0] == 3'h0 && rdata[31:8] == 24'h0; endproperty
  a_stat0: assert property (p_stat0) else $error("status low bits not zero");
  property p_ctl0; rvalid && ra_ff == 13'h8 |-> rdata[31:6] == 26'h0; endproperty
  a_ctl0: assert property (p_ctl0) else $error("control top bits not zero");
  property p_cfg2; $rose(rvalid) && ra_ff == 13'h1004 && md_ff == 3'h7 |-> rdata[7:0] ==
    {1'b0, $past(irq_line_level), $past(cfg_irq_sel), $past(cfg_dma_sel)}; endproperty
  a_cfg2: assert property (p_cfg2) else $error("second config not mirroring selections");
  property p_rev_init; md_ff == 3'h3 && $past(md_ff) == 3'h3 && cd_ff && $past(cd_ff) |-> !pins_out.ninit;
  endproperty
  a_rev_init: assert property (p_rev_init) else $error("init high in reverse");
  property p_oe; md_ff == 3'h3 && $past(md_ff) == 3'h3 && !pins_out.pd_oe_n |->
    $past(pins_in.perror, 2) && !$past(cd_ff); endproperty
  a_oe: assert property (p_oe) else $error("data bus driven without forward acknowledge");
  property p_stb; md_ff == 3'h2 && $past(md_ff) == 3'h2 && $rose(pins_out.nstrobe) |-> lo_ff == `ECP_STB_CYC;
  endproperty
  a_stb: assert property (p_stb) else $error("compatibility strobe width wrong");
  property p_fhold; md_ff == 3'h3 && $past(md_ff) == 3'h3 && $rose(pins_out.nstrobe) |->
    $past(pins_in.busy, 3); endproperty
  a_fhold: assert property (p_fhold) else $error("strobe released before busy");
  property p_err; err_irq |-> $past(md_ff) == 3'h3 && !$past(cd_ff); endproperty
  a_err: assert property (p_err) else $error("fault interrupt outside forward extended mode");
endmodule // ecp_parallel_port_chk

bind ecp_parallel_port ecp_parallel_port_chk #(.DEPTH(DEPTH)) u_chk (.sys_clk, .nrst, .awaddr, .awvalid,
  .awready, .wdata, .wstrb, .wvalid, .wready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .cfg_irq_sel, .cfg_dma_sel, .irq_line_level, .pins_in, .pins_out, .err_irq);

// file: verification/ecp_printer_model.sv
// behavioural peripheral on the far side of the parallel link
// assumes host lines are sampled on sys_clk; dly slows every answer
module ecp_printer_model (
  // clock
  input wire logic              sys_clk,
  // link
  input wire ecp_pkg::pin_out_s po,
  output ecp_pkg::pin_in_s      pi,
  // bench controls
  input wire logic              hint_n,
  input wire logic [3:0]        dly,
  output logic                  got = 1'b0,
  output logic [8:0]            got_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] tx[$];
  logic       nack_ff = 1'b1;
  logic       busy_ff = 1'b0;
  logic       perr_ff = 1'b1;
  logic [7:0] dr_ff = 8'h0;
  int         w = 0;
  // host owns the data lines unless it has turned them around
  assign pi = {nack_ff, busy_ff, perr_ff, 1'b1, hint_n, po.pd_oe_n ? dr_ff : po.pd};
  // one handshake step per clock, after the chosen delay
  always @(posedge sys_clk) begin
    got <= 1'b0;
    if (w > 0) begin
      w <= w - 1;
    end else if (!po.ninit && po.nselectin) begin
      perr_ff <= 1'b0;
      if (!po.nautofd && po.pd_oe_n && nack_ff && !perr_ff && tx.size() > 0) begin
        {busy_ff, dr_ff} <= tx.pop_front();
        nack_ff <= 1'b0;
        w <= dly;
      end else if (po.nautofd && !nack_ff) begin
        nack_ff <= 1'b1;
        dr_ff <= ~dr_ff;
        w <= dly;
      end
    end else begin
      perr_ff <= 1'b1;
      if (!po.nstrobe && !busy_ff) begin
        busy_ff <= 1'b1;
        got <= 1'b1;
        got_b <= {po.nautofd, po.pd};
        w <= dly;
      end else if (po.nstrobe && busy_ff) begin
        busy_ff <= 1'b0;
        w <= dly;
      end
    end
  end
endmodule // ecp_printer_model

// file: verification/tb_ecp_parallel_port.sv
// self-checking bench for the parallel port and its peripheral model
// assumes the checker binds itself; one 100 MHz clock
module tb_ecp_parallel_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic [12:0]       awaddr = 13'h0;
  logic [12:0]       araddr = 13'h0;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic [2:0]        cfg_irq_sel = 3'h0;
  logic [2:0]        cfg_dma_sel = 3'h0;
  logic              irq_line_level = 1'b0;
  logic              hint_n = 1'b1;
  logic [3:0]        dly = 4'h0;
  logic              awready, wready, bvalid, arready, rvalid, err_irq, got, dma_req;
  logic [1:0]        rresp, bresp;
  logic [31:0]       rdata;
  logic [8:0]        got_b;
  ecp_pkg::pin_in_s  pins_in;
  ecp_pkg::pin_out_s pins_out;
  logic [15:0]       rq[$];
  logic [8:0]        fq[$];
  logic [7:0]        t[16];
  logic [2:0]        md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [7:0]        b;
  logic [31:0]       seed = 32'h9EF5;
  int                num_errors = 0;
  int                check_count = 0;
  int                i;

  always #5 sys_clk = ~sys_clk;

  ecp_parallel_port dut (.sys_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cfg_irq_sel,
    .cfg_dma_sel, .irq_line_level, .pins_in, .pins_out, .err_irq, .dma_req);
  ecp_printer_model peri (.sys_clk, .po(pins_out), .pi(pins_in), .hint_n, .dly, .got, .got_b);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (e !== s) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic timeout_hit();
    num_errors++;
    results();
  endtask

  task automatic wr(logic [12:0] a, logic [7:0] d, logic [3:0] s = 4'hF);
    int n;
    logic [31:0] eb;
    eb = (a inside {13'h0, 13'h4, 13'h8, 13'h1000, 13'h1004, 13'h1008}) ? 32'h0 : 32'h2;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk("bresp", eb, {30'h0, bresp});
        break;
      end
    end
    bready <= 1'b0;
    if (n == 200) timeout_hit();
  endtask

  task automatic rd(logic [12:0] a, logic [7:0] m, logic [7:0] e);
    int n;
    @(posedge sys_clk);
    rq.push_back({m, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 200) timeout_hit();
  endtask

  // wait for the link to go quiet, then let the synchronisers catch up
  task automatic settle();
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge sys_clk);
      if (fq.size() == 0 && peri.tx.size() == 0 && pins_in.nack && pins_out.nstrobe) break;
    end
    if (n == 3000) timeout_hit();
    repeat (20) @(posedge sys_clk);
  endtask

  // compare each read and each link byte with the oldest note
  always @(posedge sys_clk) begin
    if (rvalid && rready) begin
      chk("rdata", {24'h0, rq[0][7:0]}, rdata & {24'hFFFFFF, rq[0][15:8]});
      void'(rq.pop_front());
    end
    if (got) begin
      chk("link byte", {23'h0, fq[0]}, {23'h0, got_b});
      void'(fq.pop_front());
    end
  end

  // main sequence
  initial begin
    {cfg_irq_sel, cfg_dma_sel, irq_line_level} <= 7'(rnd());
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(13'h0008, 8'hFF, 8'h00);
    rd(13'h1008, 8'hFF, 8'h15);
    wr(13'h0008, 8'hC4);
    rd(13'h0008, 8'hFF, 8'h04);
    wr(13'h0008, 8'hFF, 4'h0);
    rd(13'h0008, 8'hFF, 8'h04);
    rd(13'h0010, 8'hFF, 8'h00);
    wr(13'h0010, 8'h55);
    rd(13'h0004, 8'hFF, 8'hF8);
    b = 8'(rnd());
    wr(13'h0000, b);
    rd(13'h0000, 8'hFF, b);
    for (i = 0; i < 6; i++) begin
      wr(13'h1008, {md[i], 5'h0});
      rd(13'h1008, 8'hE0, {md[i], 5'h0});
    end
    rd(13'h1000, 8'hFF, 8'h08);
    rd(13'h1004, 8'hFF, {1'b0, irq_line_level, cfg_irq_sel, cfg_dma_sel});
    // compatibility fifo, hardware strobe
    wr(13'h1008, 8'h40);
    for (i = 0; i < 3; i++) begin
      b = 8'(rnd());
      fq.push_back({1'b1, b});
      wr(13'h1000, b);
    end
    settle();
    // extended forward with a slow peripheral
    dly <= 4'(rnd());
    wr(13'h1008, 8'h60);
    b = 8'h80 | 8'(rnd());
    fq.push_back({1'b0, b});
    wr(13'h0000, b);
    for (i = 0; i < 2; i++) begin
      b = 8'(rnd());
      fq.push_back({1'b1, b});
      wr(13'h1000, b);
    end
    settle();
    hint_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("err_irq", 32'h1, {31'h0, err_irq});
    hint_n <= 1'b1;
    // extended reverse with run-length and channel bytes
    dly <= 4'h1;
    wr(13'h0008, 8'h24);
    peri.tx.push_back({1'b0, 8'h02});
    peri.tx.push_back({1'b1, 8'hA5});
    peri.tx.push_back({1'b0, 8'h85});
    peri.tx.push_back({1'b1, 8'h3C});
    settle();
    for (i = 0; i < 5; i++) rd(13'h1000, 8'hFF, i < 3 ? 8'hA5 : 8'h3C);
    // shared fifo filled past full, then drained past empty
    wr(13'h0008, 8'h04);
    wr(13'h1008, 8'h00);
    wr(13'h1008, 8'hC8);
    for (i = 0; i < 17; i++) begin
      b = 8'(rnd());
      if (i < 16) t[i] = b;
      wr(13'h1000, b);
    end
    rd(13'h1008, 8'hFB, 8'hCA);
    chk("dma_req", 32'h1, {31'h0, dma_req});
    for (i = 0; i < 17; i++) rd(13'h1000, 8'hFF, t[i < 16 ? i : 15]);
    rd(13'h1008, 8'hFB, 8'hC9);
    chk("dma_req", 32'h0, {31'h0, dma_req});
    results();
  end
endmodule // tb_ecp_parallel_port
